// [pkg/pdpram_consts.svh]
// Purpose: Shared constants for the pseudo dual-port embedded RAM block.
// Assumes: Included by its bare name before the package and the design.
// Notes: Sizes are the largest organisation; narrower ones use the low part.
//
// Contract
// R1: The block stores 4096 bits, usable as single, pseudo dual-port or FIFO storage.
// R2: Write port and read port are independent and work at the same time.
// R3: The 256x16 organisation has 8-bit addresses and 16-bit data on both ports.
// R4: 512x8, 1024x4, 2048x2 use 9, 10, 11 address bits and no mask.
// R5: In the 16-bit organisation a mask gates the write of each bit.
// R6: Mask bit zero writes the data bit; mask bit one keeps the stored bit.
// R7: Each port clock samples rising by default, each optionally falling instead.
// R8: Write data, write address and read address are registered at the array input.
// R9: Contents are preloaded before user operation begins.
// R10: User logic uses the block as ROM by preloading and never writing.
// R11: The preload never covers location zero; it starts out zero.
// R12: A write happens only on an active edge with enable and clock gate high.
// R13: Read data updates only on an active edge with enable and gate high.
`ifndef PDPRAM_CONSTS_SVH
`define PDPRAM_CONSTS_SVH

`define PDP_ARRAY_BITS 4096
`define PDP_MAX_DW 16
`define PDP_MAX_AW 11
`define PDP_MASK_DW 16
`define PDP_RESET_WORD 16'h0000

`endif

// [pkg/pdpram_pkg.sv]
// Purpose: Types for the pseudo dual-port embedded RAM block.
// Assumes: pdpram_consts.svh supplies the sizes.
// Notes: Pin bundles are held at the largest data and address widths.
`include "pdpram_consts.svh"
`default_nettype none

package pdpram_pkg;

    typedef struct packed {
        logic clk;
        logic en;
        logic gate;
        logic [`PDP_MAX_AW-1:0] addr;
        logic [`PDP_MAX_DW-1:0] data;
        logic [`PDP_MAX_DW-1:0] mask;
    } pdpram_wpin_s;

    typedef struct packed {
        logic clk;
        logic en;
        logic gate;
        logic [`PDP_MAX_AW-1:0] addr;
    } pdpram_rpin_s;

    typedef struct packed {
        logic [`PDP_ARRAY_BITS-1:0] mem;
        pdpram_wpin_s w_s1;
        pdpram_wpin_s w_s2;
        logic wclk_d;
        pdpram_rpin_s r_s1;
        pdpram_rpin_s r_s2;
        logic rclk_d;
        logic w_pend;
        logic [`PDP_MAX_AW-1:0] w_addr;
        logic [`PDP_MAX_DW-1:0] w_data;
        logic [`PDP_MAX_DW-1:0] w_mask;
        logic r_pend;
        logic [`PDP_MAX_AW-1:0] r_addr;
        logic [`PDP_MAX_DW-1:0] r_data;
    } pdpram_state_s;

endpackage

`default_nettype wire

// [testbench/pdpram_user.sv]
// Purpose: User-logic model that drives one store port and one fetch port of the RAM.
// Assumes: Driven on the falling edge of clk_i; port clocks are slow toggling pins.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module pdpram_user #(
    parameter int DW = 16,
    parameter int AW = 8,
    parameter bit FALL = 1'b0
) (
    input wire logic clk_i,
    output logic sclk_o,
    output logic sen_o,
    output logic sgate_o,
    output logic [AW-1:0] sloc_o,
    output logic [DW-1:0] sdat_o,
    output logic [DW-1:0] smask_o,
    output logic fclk_o,
    output logic fen_o,
    output logic fgate_o,
    output logic [AW-1:0] floc_o,
    input wire logic [DW-1:0] fdat_i
);
    // Port clocks idle at the inactive level, and write controls stay off until used.
    initial begin
        sclk_o = FALL;
        fclk_o = FALL;
        sen_o = 1'b0;
        sgate_o = 1'b0;
        fen_o = 1'b0;
        fgate_o = 1'b0;
        sloc_o = '0;
        sdat_o = '0;
        smask_o = '0;
        floc_o = '0;
    end

    task automatic store(input logic [AW-1:0] a, input logic [DW-1:0] d,
                         input logic [DW-1:0] m, input logic en, input logic gt);
        sloc_o = a;
        sdat_o = d;
        smask_o = m;
        sen_o = en;
        sgate_o = gt;
        repeat (3) @(negedge clk_i);
        sclk_o = ~FALL;
        repeat (4) @(negedge clk_i);
        sclk_o = FALL;
        repeat (3) @(negedge clk_i);
        sen_o = 1'b0;
        sgate_o = 1'b0;
        sloc_o = ~a;
        sdat_o = ~d;
        @(negedge clk_i);
    endtask

    task automatic fetch(input logic [AW-1:0] a, input logic en, input logic gt,
                         output logic [DW-1:0] d);
        floc_o = a;
        fen_o = en;
        fgate_o = gt;
        repeat (3) @(negedge clk_i);
        fclk_o = ~FALL;
        repeat (6) @(negedge clk_i);
        d = fdat_i;
        fclk_o = FALL;
        repeat (3) @(negedge clk_i);
        fen_o = 1'b0;
        fgate_o = 1'b0;
        floc_o = ~a;
        @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// [testbench/tb_pseudo_dual_port_block_ram.sv]
// Purpose: Self-checking bench for the RAM in the 256x16 and 512x8 organisations.
// Assumes: Reset stands in for configuration and loads the preload image.
// Notes: The wide instance uses rising port clocks, the narrow one falling clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_pseudo_dual_port_block_ram;
    localparam logic [4095:0] IMG_A = {256{16'ha5c3}};
    localparam logic [4095:0] IMG_B = {512{8'h3c}};
    logic clk_i, resetn_i;
    logic a_sc, a_se, a_sg, a_fc, a_fe, a_fg, b_sc, b_se, b_sg, b_fc, b_fe, b_fg;
    logic [7:0] a_sl, a_fl, b_sd, b_sm, b_fd, gb;
    logic [8:0] b_sl, b_fl;
    logic [15:0] a_sd, a_sm, a_fd, ga;
    int num_errors = 0;
    int samples_checked = 0;

    pdpram_top #(.INIT(IMG_A)) pdpram_top_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .store_clock_i(a_sc), .store_enable_i(a_se), .store_clock_gate_i(a_sg),
        .store_location_i(a_sl), .store_data_i(a_sd), .store_mask_i(a_sm),
        .fetch_clock_i(a_fc), .fetch_enable_i(a_fe), .fetch_clock_gate_i(a_fg),
        .fetch_location_i(a_fl), .fetch_data_o(a_fd));
    pdpram_user pdpram_user_i (.clk_i(clk_i), .sclk_o(a_sc), .sen_o(a_se), .sgate_o(a_sg),
        .sloc_o(a_sl), .sdat_o(a_sd), .smask_o(a_sm), .fclk_o(a_fc), .fen_o(a_fe),
        .fgate_o(a_fg), .floc_o(a_fl), .fdat_i(a_fd));
    pdpram_top #(.DATA_W(8), .STORE_FALL(1'b1), .FETCH_FALL(1'b1), .INIT(IMG_B))
        pdpram_top_n_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .store_clock_i(b_sc), .store_enable_i(b_se), .store_clock_gate_i(b_sg),
        .store_location_i(b_sl), .store_data_i(b_sd), .store_mask_i(b_sm),
        .fetch_clock_i(b_fc), .fetch_enable_i(b_fe), .fetch_clock_gate_i(b_fg),
        .fetch_location_i(b_fl), .fetch_data_o(b_fd));
    pdpram_user #(.DW(8), .AW(9), .FALL(1'b1)) pdpram_user_n_i (.clk_i(clk_i),
        .sclk_o(b_sc), .sen_o(b_se), .sgate_o(b_sg), .sloc_o(b_sl), .sdat_o(b_sd),
        .smask_o(b_sm), .fclk_o(b_fc), .fen_o(b_fe), .fgate_o(b_fg), .floc_o(b_fl),
        .fdat_i(b_fd));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic check(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic print_verdict();
        $display("Errors %0d, comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic test_preload();
        pdpram_user_i.fetch(8'h05, 1'b1, 1'b1, ga);
        check(ga, 16'ha5c3);
        pdpram_user_i.fetch(8'h00, 1'b1, 1'b1, ga);
        check(ga, 16'h0000);
    endtask

    task automatic test_both_ports();
        pdpram_user_i.store(8'hff, 16'h1234, 16'h0000, 1'b1, 1'b1);
        fork
            pdpram_user_i.store(8'h10, 16'h5a5a, 16'h0000, 1'b1, 1'b1);
            pdpram_user_i.fetch(8'hff, 1'b1, 1'b1, ga);
        join
        check(ga, 16'h1234);
        pdpram_user_i.fetch(8'h10, 1'b1, 1'b1, ga);
        check(ga, 16'h5a5a);
    endtask

    task automatic test_mask_and_refusal();
        pdpram_user_i.store(8'hff, 16'hffff, 16'h00ff, 1'b1, 1'b1);
        pdpram_user_i.store(8'hff, 16'h0000, 16'h0000, 1'b0, 1'b1);
        pdpram_user_i.store(8'hff, 16'h0000, 16'h0000, 1'b1, 1'b0);
        pdpram_user_i.fetch(8'hff, 1'b1, 1'b1, ga);
        check(ga, 16'hff34);
        pdpram_user_i.fetch(8'h05, 1'b0, 1'b1, ga);
        check(ga, 16'hff34);
        pdpram_user_i.fetch(8'h05, 1'b1, 1'b0, ga);
        check(ga, 16'hff34);
    endtask

    task automatic test_narrow();
        pdpram_user_n_i.fetch(9'h003, 1'b1, 1'b1, gb);
        check({8'h00, gb}, 16'h003c);
        pdpram_user_n_i.fetch(9'h000, 1'b1, 1'b1, gb);
        check({8'h00, gb}, 16'h0000);
        pdpram_user_n_i.store(9'h1ff, 8'h81, 8'hff, 1'b1, 1'b1);
        pdpram_user_n_i.fetch(9'h1ff, 1'b1, 1'b1, gb);
        check({8'h00, gb}, 16'h0081);
        pdpram_user_n_i.store(9'h1ff, 8'h00, 8'h00, 1'b0, 1'b1);
        pdpram_user_n_i.store(9'h1ff, 8'h00, 8'h00, 1'b1, 1'b0);
        pdpram_user_n_i.fetch(9'h003, 1'b0, 1'b1, gb);
        check({8'h00, gb}, 16'h0081);
        pdpram_user_n_i.fetch(9'h003, 1'b1, 1'b0, gb);
        check({8'h00, gb}, 16'h0081);
        pdpram_user_n_i.fetch(9'h1ff, 1'b1, 1'b1, gb);
        check({8'h00, gb}, 16'h0081);
    endtask

    initial begin
        #20000;
        num_errors++;
        print_verdict();
    end

    initial begin
        resetn_i = 1'b0;
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        test_preload();
        test_both_ports();
        test_mask_and_refusal();
        test_narrow();
        print_verdict();
    end
endmodule
`default_nettype wire

// [verilog/pdpram_top.sv]
// Purpose: Pseudo dual-port 4 kbit embedded RAM with separate store and fetch ports.
// Assumes: Port clocks are slow pins sampled by clk_i; inputs stable around each edge.
// Notes: Reset stands in for configuration and loads INIT, except location zero.
`timescale 1ns/1ps
`include "pdpram_consts.svh"
`default_nettype none

module pdpram_top #(
    parameter int DATA_W = `PDP_MAX_DW,
    parameter bit STORE_FALL = 1'b0,
    parameter bit FETCH_FALL = 1'b0,
    parameter logic [`PDP_ARRAY_BITS-1:0] INIT = '0,
    localparam int ADDR_W = $clog2(`PDP_ARRAY_BITS / DATA_W)
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic store_clock_i,
    input wire logic store_enable_i,
    input wire logic store_clock_gate_i,
    input wire logic [ADDR_W-1:0] store_location_i,
    input wire logic [DATA_W-1:0] store_data_i,
    input wire logic [DATA_W-1:0] store_mask_i,
    input wire logic fetch_clock_i,
    input wire logic fetch_enable_i,
    input wire logic fetch_clock_gate_i,
    input wire logic [ADDR_W-1:0] fetch_location_i,
    output logic [DATA_W-1:0] fetch_data_o
);

    localparam int MAXAW = `PDP_MAX_AW;
    localparam int MAXDW = `PDP_MAX_DW;
    // Location zero is cleared out of the preload image.
    localparam logic [`PDP_ARRAY_BITS-1:0] INIT_EFF = (INIT >> DATA_W) << DATA_W; // R11 R9

    pdpram_pkg::pdpram_state_s st_reg;
    pdpram_pkg::pdpram_state_s st_next;
    pdpram_pkg::pdpram_wpin_s wpin;
    pdpram_pkg::pdpram_rpin_s rpin;
    logic w_edge;
    logic r_edge;
    logic [`PDP_MAX_DW-1:0] mask_eff;

    function automatic logic [`PDP_MAX_DW-1:0] word_at(
        input logic [`PDP_ARRAY_BITS-1:0] m,
        input logic [`PDP_MAX_AW-1:0] a
    );
        logic [`PDP_MAX_DW-1:0] w;
        w = '0;
        for (int i = 0; i < DATA_W; i++) begin
            w[i] = m[int'(a) * DATA_W + i];
        end
        return w;
    endfunction

    // ----------------------------------------------------------------
    // Pin bundles
    // ----------------------------------------------------------------
    // Only the 16-bit organisation has a mask; the others always write.
    assign mask_eff = (DATA_W == `PDP_MASK_DW) ? MAXDW'(store_mask_i) : '0; // R4 R5

    always_comb begin
        wpin.clk = store_clock_i;
        wpin.en = store_enable_i;
        wpin.gate = store_clock_gate_i;
        wpin.addr = MAXAW'(store_location_i);
        wpin.data = MAXDW'(store_data_i);
        wpin.mask = mask_eff;
        rpin.clk = fetch_clock_i;
        rpin.en = fetch_enable_i;
        rpin.gate = fetch_clock_gate_i;
        rpin.addr = MAXAW'(fetch_location_i);
    end

    // ----------------------------------------------------------------
    // Active edge detection
    // ----------------------------------------------------------------
    // Each port picks its own edge; only the second sync stage is examined.
    // Sync stages clear on reset, so a rising-mode port clock must be low at release.
    assign w_edge = STORE_FALL ? (st_reg.wclk_d & ~st_reg.w_s2.clk)
                               : (st_reg.w_s2.clk & ~st_reg.wclk_d); // R7
    assign r_edge = FETCH_FALL ? (st_reg.rclk_d & ~st_reg.r_s2.clk)
                               : (st_reg.r_s2.clk & ~st_reg.rclk_d); // R7

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        int base;
        base = int'(st_reg.w_addr) * DATA_W;
        st_next = st_reg;
        st_next.w_s1 = wpin;
        st_next.w_s2 = st_reg.w_s1;
        st_next.wclk_d = st_reg.w_s2.clk;
        st_next.r_s1 = rpin;
        st_next.r_s2 = st_reg.r_s1;
        st_next.rclk_d = st_reg.r_s2.clk;
        // Input registers at the array, loaded only on an enabled edge.
        st_next.w_pend = w_edge & st_reg.w_s2.en & st_reg.w_s2.gate; // R12
        if (w_edge && st_reg.w_s2.en && st_reg.w_s2.gate) begin
            st_next.w_addr = st_reg.w_s2.addr; // R8 R3
            st_next.w_data = st_reg.w_s2.data; // R8
            st_next.w_mask = st_reg.w_s2.mask;
        end
        st_next.r_pend = r_edge & st_reg.r_s2.en & st_reg.r_s2.gate; // R13
        if (r_edge && st_reg.r_s2.en && st_reg.r_s2.gate) begin
            st_next.r_addr = st_reg.r_s2.addr; // R8 R3
        end
        // A read in the cycle of a write returns the old word.
        if (st_reg.r_pend) begin
            st_next.r_data = word_at(st_reg.mem, st_reg.r_addr); // R13 R2
        end
        if (st_reg.w_pend) begin
            for (int i = 0; i < DATA_W; i++) begin
                if (!st_reg.w_mask[i]) begin
                    st_next.mem[base + i] = st_reg.w_data[i]; // R5 R6 R1
                end
            end
        end
    end

    // Reset stands in for configuration: the preload lands and location zero stays clear.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
            st_reg.mem <= INIT_EFF; // R9 R11
            st_reg.r_data <= `PDP_RESET_WORD;
        end else begin
            st_reg <= st_next;
        end
    end

    assign fetch_data_o = st_reg.r_data[DATA_W-1:0];

    // ----------------------------------------------------------------
    // Store port checks
    // ----------------------------------------------------------------
    a_write_launch: assert property (@(posedge clk_i) disable iff (!resetn_i) // R12
        (w_edge && st_reg.w_s2.en && st_reg.w_s2.gate) |=> st_reg.w_pend)
        else $error("Enabled store edge did not launch a write.");

    a_write_gated: assert property (@(posedge clk_i) disable iff (!resetn_i) // R12
        !(w_edge && st_reg.w_s2.en && st_reg.w_s2.gate) |=> ##1 $stable(st_reg.mem))
        else $error("Array changed without an enabled store edge.");

    a_addr_capture: assert property (@(posedge clk_i) disable iff (!resetn_i) // R8
        (w_edge && st_reg.w_s2.en && st_reg.w_s2.gate)
        |=> st_reg.w_addr == $past(st_reg.w_s2.addr))
        else $error("Store address not registered at the array input.");

    a_mask_write: assert property (@(posedge clk_i) disable iff (!resetn_i) // R5
        st_reg.w_pend |=> ((word_at(st_reg.mem, $past(st_reg.w_addr))
            ^ $past(st_reg.w_data)) & ~$past(st_reg.w_mask)
            & MAXDW'((1 << DATA_W) - 1)) == '0)
        else $error("Unmasked bit did not take the store data.");

    a_mask_hold: assert property (@(posedge clk_i) disable iff (!resetn_i) // R6
        st_reg.w_pend |=> ((word_at(st_reg.mem, $past(st_reg.w_addr))
            ^ word_at($past(st_reg.mem), $past(st_reg.w_addr)))
            & $past(st_reg.w_mask)) == '0)
        else $error("Masked bit changed during a store.");

    a_narrow_nomask: assert property (@(posedge clk_i) disable iff (!resetn_i) // R4
        ((DATA_W != `PDP_MASK_DW) && st_reg.w_pend)
        |=> word_at(st_reg.mem, $past(st_reg.w_addr)) == $past(st_reg.w_data))
        else $error("Narrow organisation applied a mask.");

    a_data_capture: assert property (@(posedge clk_i) disable iff (!resetn_i) // R8
        (w_edge && st_reg.w_s2.en && st_reg.w_s2.gate)
        |=> st_reg.w_data == $past(st_reg.w_s2.data))
        else $error("Store data not registered at the array input.");

    a_store_refused: assert property (@(posedge clk_i) disable iff (!resetn_i) // R12
        (w_edge && !(st_reg.w_s2.en && st_reg.w_s2.gate))
        |=> !st_reg.w_pend)
        else $error("Refused store edge launched a write.");

    a_store_polarity: assert property (@(posedge clk_i) disable iff (!resetn_i) // R7
        w_edge |-> (st_reg.w_s2.clk != STORE_FALL))
        else $error("Store edge detected on the wrong clock level.");

    a_store_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i) // R7
        w_edge |=> !w_edge)
        else $error("Store edge detector held for more than one cycle.");

    // ----------------------------------------------------------------
    // Fetch port checks
    // ----------------------------------------------------------------
    a_fetch_launch: assert property (@(posedge clk_i) disable iff (!resetn_i) // R13
        (r_edge && st_reg.r_s2.en && st_reg.r_s2.gate) |=> ##1
        fetch_data_o == DATA_W'(word_at($past(st_reg.mem), st_reg.r_addr)))
        else $error("Enabled fetch edge did not deliver the addressed word.");

    a_fetch_hold: assert property (@(posedge clk_i) disable iff (!resetn_i) // R13
        !st_reg.r_pend |=> $stable(fetch_data_o))
        else $error("Fetch data changed without an enabled fetch edge.");

    a_fetch_addr: assert property (@(posedge clk_i) disable iff (!resetn_i) // R8
        (r_edge && st_reg.r_s2.en && st_reg.r_s2.gate)
        |=> st_reg.r_addr == $past(st_reg.r_s2.addr))
        else $error("Fetch address not registered at the array input.");

    a_fetch_gated: assert property (@(posedge clk_i) disable iff (!resetn_i) // R13
        !(r_edge && st_reg.r_s2.en && st_reg.r_s2.gate)
        |=> !st_reg.r_pend)
        else $error("Fetch launched without an enabled fetch edge.");

    a_fetch_polarity: assert property (@(posedge clk_i) disable iff (!resetn_i) // R7
        r_edge |-> (st_reg.r_s2.clk != FETCH_FALL))
        else $error("Fetch edge detected on the wrong clock level.");

    a_fetch_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i) // R7
        r_edge |=> !r_edge)
        else $error("Fetch edge detector held for more than one cycle.");

    // ----------------------------------------------------------------
    // Preload checks
    // ----------------------------------------------------------------
    a_loc0_clear: assert property (@(posedge clk_i) disable iff (!resetn_i) // R11
        $rose(resetn_i) |-> word_at(st_reg.mem, '0) == '0)
        else $error("Location zero came out of reset preloaded.");

endmodule

`default_nettype wire
